// ===== core/flyback_defs.svh
/*
 constants of the flyback mode and protection sequencer: register map,
 field positions, reset values and timing counts.
 assumes a 100 MHz clock; included by bare name.
*/
`ifndef FLYBACK_DEFS_SVH
`define FLYBACK_DEFS_SVH

// register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
// control fields
`define CTRL_LIGHT_BIT 0
`define CTRL_MINON_LSB 8
`define CTRL_RESET 32'h0000_0A01
// clock
`define CLK_PS 10000
`define CLK_NS 10
// sr edge rate: picoseconds moved per microsecond
`define SR_STEP_PS 1500
`define US_CYC (1000 / `CLK_NS)
// protection times
`define CLAMP_US 1500
`define CLAMP_CYC (`CLAMP_US * 1000 / `CLK_NS)
`define OCP_US 1500
`define OCP_CYC (`OCP_US * 1000 / `CLK_NS)
`define HICCUP_MS 40
`define HICCUP_CYC (`HICCUP_MS * 1000000 / `CLK_NS)
`define SPECIAL_MS 200
`define SPECIAL_CYC (`SPECIAL_MS * 1000000 / `CLK_NS)
// soft stop sink relative to soft start current, in tenths
`define SS_STOP_SINK_X10 8'h0F

`endif

// ===== core/flyback_pkg.sv
/*
 types of the flyback mode and protection sequencer.
 assumes nothing beyond a SystemVerilog compiler.
*/
package flyback_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_SOFTSTART = 3'b001,
      ST_RUN = 3'b010,
      ST_RECOVER = 3'b011,
      ST_SOFTSTOP = 3'b100,
      ST_HICCUP = 3'b101
   } seq_state_t;
endpackage

// ===== core/sr_ramp.sv
/*
 synchronous rectifier width ramp: moves the width toward a target or
 toward zero at a fixed edge rate per microsecond.
 assumes a 100 MHz clock and a synchronous active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flyback_defs.svh"
module sr_ramp (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic clear_i,
   input wire logic phase_in_i,
   input wire logic [7:0] target_i,
   // result
   output logic [7:0] width_o
);
   logic [6:0] us_cnt;
   logic [14:0] frac;
   logic tick;
   logic step;

   assign tick = (us_cnt == 7'(`US_CYC - 1));
   assign step = tick && (frac + 15'(`SR_STEP_PS) >= 15'(`CLK_PS));

   always_ff @(posedge clk_i) begin
      if (rst_i || tick) begin
         us_cnt <= 7'h00;
      end else begin
         us_cnt <= 7'(us_cnt + 7'd1);
      end
   end

   // fractional edge position accumulates per microsecond
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         frac <= 15'h0000;
      end else if (step) begin
         frac <= 15'(frac + 15'(`SR_STEP_PS) - 15'(`CLK_PS));
      end else if (tick) begin
         frac <= 15'(frac + 15'(`SR_STEP_PS));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         width_o <= 8'h00;
      end else if (step && phase_in_i && width_o < target_i) begin
         width_o <= 8'(width_o + 8'd1);
      end else if (step && (!phase_in_i || width_o > target_i) && width_o != 8'h00) begin
         width_o <= 8'(width_o - 8'd1);
      end
   end

   a_ramp_step_size: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(clear_i) && width_o != $past(width_o)) |->
         ($past(step) && (width_o == 8'($past(width_o) + 8'd1) || width_o == 8'($past(width_o) - 8'd1))))
      else $error("sr width moved faster than the edge rate");

   a_ramp_out_dir: assert property (@(posedge clk_i) disable iff (rst_i || clear_i)
      (!phase_in_i && !$past(phase_in_i) && !$past(clear_i)) |-> (width_o <= $past(width_o)))
      else $error("sr width grew during phase out");
endmodule
`default_nettype wire

// ===== core/flyback_sequencer.sv
/*
 flyback mode and protection sequencer: light load and forced continuous
 conduction selection, sr phase in and out, pulse skip, soft stop,
 feedback recovery, overcurrent period counter and hiccup timers, with
 a classic wishbone register slave.
 assumes comparator inputs synchronous to clk_i and one period_start_i
 pulse per switching period from the oscillator.
*/
// Contract
// - below light-load threshold the sr drive turns off; primary keeps full pwm
// - above light-load threshold run forced continuous conduction with sr drive active
// - leaving light load, sr edges widen at most 1.5 ns per microsecond
// - continuous to discontinuous, sr pulses narrow at the same rate
// - error at minimum clamp skips pulses; above it in light load, minimum on-time
// - in light load each sr pulse ends before the next primary pulse edge
// - variant without light load never skips and always runs continuous conduction
// - on disable, sr off at once; primary width falls to minimum, then zero
// - soft stop discharges soft-start reference with about 1.5x soft-start current
// - secondary supply in lockout stops error-level transmission to the primary
// - max current, clamped error, low feedback: discharge reference to feedback, restart
// - error above maximum clamp longer than 1.5 ms enters hiccup
// - during precharge soft start, reference 100 mV above feedback re-enters recovery
// - secondary supply entering lockout starts a 200 ms hiccup instead of 40 ms
// - current sense above 120 mV ends the present primary pulse immediately
// - overcurrent every period for 1.5 ms enters 40 ms hiccup, then soft start
// - counter latches last state; one clean period after a hit still counts
// - counter resets only after two consecutive periods without overcurrent; code also clears it whenever not in soft start, run or recovery
`timescale 1ns/10ps
`default_nettype none
`include "flyback_defs.svh"
module flyback_sequencer
   import flyback_pkg::*;
#(
   parameter int unsigned CLAMP_CYC = `CLAMP_CYC,
   parameter int unsigned OCP_CYC = `OCP_CYC,
   parameter int unsigned HICCUP_CYC = `HICCUP_CYC,
   parameter int unsigned SPECIAL_CYC = `SPECIAL_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // oscillator and loop
   input wire logic period_start_i,
   input wire logic [7:0] loop_width_i,
   // comparator decisions
   input wire logic enable_i,
   input wire logic err_below_light_i,
   input wire logic err_at_min_clamp_i,
   input wire logic err_at_max_clamp_i,
   input wire logic cs_at_max_i,
   input wire logic cs_over_limit_i,
   input wire logic fb_below_ref_i,
   input wire logic ss_above_fb_i,
   input wire logic ss_equals_fb_i,
   input wire logic softstart_done_i,
   input wire logic secondary_uvlo_i,
   // drives and analog controls
   output logic gate_o,
   output logic sr_drive_o,
   output logic comp_link_o,
   output logic ss_start_o,
   output logic ss_fast_discharge_o,
   output logic [7:0] ss_sink_tenths_o,
   output logic hiccup_o
);
   seq_state_t state;
   logic [31:0] ctrl;
   logic light_support;
   logic [7:0] min_on;
   logic light_load;
   logic active;
   logic precharge;
   logic hic_long;
   logic uvlo_q;
   logic uvlo_rise;
   logic [17:0] clamp_cnt;
   logic [17:0] ocp_time;
   logic [24:0] hic_cnt;
   logic clamp_to;
   logic ocp_to;
   logic hic_enter;
   logic recovery_cond;
   logic ocp_seen;
   logic ocp_hit;
   logic streak;
   logic miss_one;
   logic [7:0] per_cnt;
   logic [7:0] period_len;
   logic [7:0] gate_width;
   logic [7:0] gate_len;
   logic [7:0] stop_width;
   logic [7:0] next_width;
   logic gate_q;
   logic gate_end;
   logic sr_q;
   logic [7:0] sr_cnt;
   logic [7:0] sr_width;
   logic [7:0] sr_target;
   logic sr_allowed;
   logic wb_req;

   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hFF) ? v : 8'(v + 8'd1);
   endfunction

   assign light_support = ctrl[`CTRL_LIGHT_BIT];
   assign min_on = ctrl[`CTRL_MINON_LSB +: 8];
   assign light_load = light_support && err_below_light_i;
   assign active = (state == ST_SOFTSTART) || (state == ST_RUN) || (state == ST_RECOVER);
   assign uvlo_rise = secondary_uvlo_i && !uvlo_q;
   assign clamp_to = (clamp_cnt >= 18'(CLAMP_CYC));
   assign ocp_to = (ocp_time >= 18'(OCP_CYC));
   assign hic_enter = active && (uvlo_rise || clamp_to || ocp_to);
   assign recovery_cond = cs_at_max_i && err_at_max_clamp_i && fb_below_ref_i;
   assign ocp_hit = ocp_seen || cs_over_limit_i;
   assign gate_end = gate_q && (cs_over_limit_i || sat_inc(per_cnt) >= gate_width);

   // primary width chosen for the coming period
   always_comb begin
      next_width = 8'h00;
      if (state == ST_SOFTSTOP) begin
         next_width = stop_width;
      end else if (active) begin
         if (light_load && err_at_min_clamp_i) begin
            next_width = 8'h00;
         end else if (light_load && loop_width_i < min_on) begin
            next_width = min_on;
         end else begin
            next_width = loop_width_i;
         end
      end
   end

   // sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_OFF;
      end else begin
         case (state)
            ST_OFF: begin
               if (enable_i) begin
                  state <= ST_SOFTSTART;
               end
            end
            ST_SOFTSTART: begin
               if (hic_enter) begin
                  state <= ST_HICCUP;
               end else if (!enable_i) begin
                  state <= ST_SOFTSTOP;
               end else if (precharge && ss_above_fb_i) begin
                  state <= ST_RECOVER;
               end else if (softstart_done_i) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (hic_enter) begin
                  state <= ST_HICCUP;
               end else if (!enable_i) begin
                  state <= ST_SOFTSTOP;
               end else if (recovery_cond) begin
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               if (hic_enter) begin
                  state <= ST_HICCUP;
               end else if (!enable_i) begin
                  state <= ST_SOFTSTOP;
               end else if (ss_equals_fb_i) begin
                  state <= ST_SOFTSTART;
               end
            end
            ST_SOFTSTOP: begin
               if (period_start_i && stop_width == 8'h00) begin
                  state <= ST_OFF;
               end
            end
            ST_HICCUP: begin
               if (hic_cnt == 25'h000_0000) begin
                  state <= enable_i ? ST_SOFTSTART : ST_OFF;
               end
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   // soft start from precharge follows recovery
   always_ff @(posedge clk_i) begin
      if (rst_i || state == ST_OFF || state == ST_HICCUP || state == ST_RUN) begin
         precharge <= 1'b0;
      end else if (state == ST_RECOVER) begin
         precharge <= 1'b1;
      end
   end

   // hiccup timer on the clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hic_cnt <= 25'h000_0000;
         hic_long <= 1'b0;
      end else if (hic_enter) begin
         hic_long <= uvlo_rise;
         hic_cnt <= uvlo_rise ? 25'(SPECIAL_CYC - 1) : 25'(HICCUP_CYC - 1);
      end else if (state == ST_HICCUP && hic_cnt != 25'h000_0000) begin
         hic_cnt <= 25'(hic_cnt - 25'd1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         uvlo_q <= 1'b0;
      end else begin
         uvlo_q <= secondary_uvlo_i;
      end
   end

   // time spent above the maximum clamp
   always_ff @(posedge clk_i) begin
      if (rst_i || !active || !err_at_max_clamp_i) begin
         clamp_cnt <= 18'h0_0000;
      end else if (!clamp_to) begin
         clamp_cnt <= 18'(clamp_cnt + 18'd1);
      end
   end

   // overcurrent latched within the period, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ocp_seen <= 1'b0;
      end else if (cs_over_limit_i) begin
         ocp_seen <= 1'b1;
      end else if (period_start_i) begin
         ocp_seen <= 1'b0;
      end
   end

   // per period overcurrent counter
   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         streak <= 1'b0;
         miss_one <= 1'b0;
      end else if (period_start_i) begin
         if (ocp_hit) begin
            streak <= 1'b1;
            miss_one <= 1'b0;
         end else if (miss_one) begin
            streak <= 1'b0;
            miss_one <= 1'b0;
         end else begin
            miss_one <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !streak) begin
         ocp_time <= 18'h0_0000;
      end else if (!ocp_to) begin
         ocp_time <= 18'(ocp_time + 18'd1);
      end
   end

   // period timing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_cnt <= 8'h00;
         period_len <= 8'h00;
      end else if (period_start_i) begin
         per_cnt <= 8'h00;
         period_len <= per_cnt;
      end else begin
         per_cnt <= sat_inc(per_cnt);
      end
   end

   // primary drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_q <= 1'b0;
         gate_width <= 8'h00;
         gate_len <= 8'h00;
      end else if (hic_enter || state == ST_HICCUP || state == ST_OFF) begin
         gate_q <= 1'b0;
      end else if (period_start_i) begin
         gate_width <= next_width;
         gate_q <= (next_width != 8'h00);
      end else if (gate_end) begin
         gate_q <= 1'b0;
         gate_len <= sat_inc(per_cnt);
      end
   end

   // soft stop width walks down to minimum, then zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_width <= 8'h00;
      end else if (state != ST_SOFTSTOP) begin
         stop_width <= gate_width;
      end else if (period_start_i) begin
         stop_width <= (stop_width > min_on) ? 8'(stop_width - 8'd1) : 8'h00;
      end
   end

   // synchronous rectifier
   assign sr_allowed = active && enable_i && !hic_enter;
   assign sr_target = (period_len > gate_len) ? 8'(period_len - gate_len) : 8'h00;

   sr_ramp u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(!sr_allowed),
      .phase_in_i(!light_load),
      .target_i(sr_target),
      .width_o(sr_width)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i || !sr_allowed) begin
         sr_q <= 1'b0;
         sr_cnt <= 8'h00;
      end else if (period_start_i) begin
         sr_q <= 1'b0;
      end else if (gate_end) begin
         sr_q <= (sr_width != 8'h00);
         sr_cnt <= 8'h00;
      end else if (sr_q) begin
         sr_cnt <= sat_inc(sr_cnt);
         if (sat_inc(sr_cnt) >= sr_width) begin
            sr_q <= 1'b0;
         end
      end
   end

   assign gate_o = gate_q && !cs_over_limit_i;
   assign sr_drive_o = sr_q;
   assign comp_link_o = !secondary_uvlo_i;
   assign ss_start_o = (state == ST_SOFTSTART);
   assign ss_fast_discharge_o = (state == ST_RECOVER);
   assign ss_sink_tenths_o = (state == ST_SOFTSTOP) ? `SS_STOP_SINK_X10 : 8'h00;
   assign hiccup_o = (state == ST_HICCUP);

   // wishbone slave, one wait state
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `CTRL_RESET;
      end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `REG_CTRL) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
               ctrl[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         if (wb_adr_i == `REG_CTRL) begin
            wb_dat_o <= ctrl;
         end else if (wb_adr_i == `REG_STATUS) begin
            wb_dat_o <= {16'h0000, sr_width, 1'b0, precharge, hic_long, streak, light_load, state};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   sequence s_clean_period;
      period_start_i && !ocp_hit && active;
   endsequence

   a_hiccup_drives_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_HICCUP) |-> (!gate_o && !sr_drive_o))
      else $error("drive active during hiccup");

   a_link_lockout: assert property (@(posedge clk_i) disable iff (rst_i)
      secondary_uvlo_i |-> !comp_link_o)
      else $error("error level sent during lockout");

   a_ocp_ends_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      (cs_over_limit_i && !period_start_i) |-> (!gate_o ##1 !gate_q))
      else $error("pulse not ended by overcurrent");

   a_stop_sr_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (active && $fell(enable_i)) |=> !sr_drive_o)
      else $error("sr still on after disable");

   a_stop_sink: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_SOFTSTOP) |-> (ss_sink_tenths_o == 8'h0F && !ss_start_o))
      else $error("soft stop sink wrong");

   a_skip_at_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
      (period_start_i && state == ST_RUN && light_load && err_at_min_clamp_i) |=> !gate_q)
      else $error("pulse issued at minimum clamp");

   a_no_skip_variant: assert property (@(posedge clk_i) disable iff (rst_i)
      (period_start_i && state == ST_RUN && !light_support && loop_width_i != 8'h00 && !hic_enter)
         |=> gate_q)
      else $error("pulse skipped without light load support");

   a_recover_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_RUN && recovery_cond && enable_i) |=>
         (state == ST_RECOVER || state == ST_HICCUP) ##0 (state == ST_HICCUP || ss_fast_discharge_o))
      else $error("recovery not entered");

   a_long_hiccup: assert property (@(posedge clk_i) disable iff (rst_i)
      (active && uvlo_rise) |=> (hiccup_o && hic_cnt == 25'(SPECIAL_CYC - 1)))
      else $error("lockout hiccup length wrong");

   a_counter_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      ((streak && !miss_one) and s_clean_period) |=> (streak && miss_one))
      else $error("single clean period cleared the counter");

   a_counter_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (miss_one and s_clean_period) |=> !streak)
      else $error("two clean periods did not clear the counter");

   a_light_sr_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (light_load && sr_width == 8'h00 && !sr_q) |=> !sr_drive_o)
      else $error("sr drive started in light load");
endmodule
`default_nettype wire

// ===== tb/flyback_partner.sv
/*
 oscillator and loop model: one period pulse every PERIOD cycles, fixed
 requested width, light-load request gated by the grounded threshold input.
 assumes the sequencer clock and its synchronous active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module flyback_partner #(
   parameter int PERIOD = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // loop requests
   input wire logic mode_grounded_i,
   input wire logic light_req_i,
   // to the sequencer
   output logic period_start_o,
   output logic [7:0] loop_width_o,
   output logic err_below_light_o
);
   int cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || cnt == PERIOD - 1) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign period_start_o = (cnt == PERIOD - 1) && !rst_i;
   assign loop_width_o = 8'h03;
   assign err_below_light_o = light_req_i && !mode_grounded_i;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
 self-checking bench of the flyback sequencer with short protection times.
 assumes the partner model drives the oscillator and loop inputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flyback_defs.svh"
module tb_top
   import flyback_pkg::*;
;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, enable = 0, light = 0, gnd = 0;
   logic min_cl = 0, max_cl = 0, cs_max = 0, cs_over = 0, fb_low = 0, ss_above = 0, ss_eq = 0;
   logic ss_done = 0, uvlo = 0, ack, pst, below, gate, sr, link, ss_st, fdis, hic;
   logic [7:0] adr = 8'h00, lw, sink;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat, q;
   int err_count = 0, total_checks = 0, cycles = 0, n;
   always #5 clk_i = ~clk_i;
   flyback_partner part (.clk_i(clk_i), .rst_i(rst_i), .mode_grounded_i(gnd), .light_req_i(light),
      .period_start_o(pst), .loop_width_o(lw), .err_below_light_o(below));
   flyback_sequencer #(.CLAMP_CYC(200), .OCP_CYC(200), .HICCUP_CYC(300), .SPECIAL_CYC(500)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .period_start_i(pst),
      .loop_width_i(lw), .enable_i(enable), .err_below_light_i(below), .err_at_min_clamp_i(min_cl),
      .err_at_max_clamp_i(max_cl), .cs_at_max_i(cs_max), .cs_over_limit_i(cs_over),
      .fb_below_ref_i(fb_low), .ss_above_fb_i(ss_above), .ss_equals_fb_i(ss_eq),
      .softstart_done_i(ss_done), .secondary_uvlo_i(uvlo), .gate_o(gate), .sr_drive_o(sr),
      .comp_link_o(link), .ss_start_o(ss_st), .ss_fast_discharge_o(fdis),
      .ss_sink_tenths_o(sink), .hiccup_o(hic));
   task automatic wrap_up();
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic state_is(input seq_state_t s);
      wb(0, `REG_STATUS, 32'h0000_0000);
      chk({29'h0, q[2:0]}, {29'h0, s});
   endtask
   task automatic period();
      do @(posedge clk_i); while (pst !== 1'b1);
   endtask
   task automatic cnt_gate(input int c);
      n = 0;
      repeat (c) begin
         #1 n += (gate === 1'b1);
         @(posedge clk_i);
      end
   endtask
   task automatic wait_hic(input logic v, input int lim);
      for (n = 0; n < lim && hic !== v; n++) @(posedge clk_i);
   endtask
   task automatic t_regs();
      wb(0, `REG_CTRL, 32'h0000_0000);
      chk(q, `CTRL_RESET);
      wb(1, 8'h10, 32'hFFFF_FFFF);
      wb(0, 8'h10, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      state_is(ST_OFF);
   endtask
   task automatic t_start();
      enable <= 1;
      state_is(ST_SOFTSTART);
      chk(ss_st, 1);
      ss_done <= 1;
      state_is(ST_RUN);
      period();
      cnt_gate(10);
      chk(n, 3);
      period();
      @(posedge clk_i);
      cs_over <= 1;
      #1 chk(gate, 0);
      wait_hic(1, 400);
      chk(hic, 1);
      cs_over <= 0;
      repeat (280) begin
         @(posedge clk_i);
         #1 if (gate !== 1'b0 || sr !== 1'b0) chk({gate, sr}, 0);
      end
      wait_hic(0, 100);
      chk(hic, 0);
   endtask
   task automatic t_ocp(input int every, input logic exp);
      logic seen;
      seen = 0;
      for (int k = 0; k < 24; k++) begin
         period();
         seen |= (hic === 1'b1);
         cs_over <= (k % every == 0);
         @(posedge clk_i);
         cs_over <= 0;
      end
      chk(seen, exp);
      wait_hic(0, 400);
   endtask
   task automatic t_uvlo();
      chk(link, 1);
      uvlo <= 1;
      @(posedge clk_i);
      #1 chk(link, 0);
      wait_hic(1, 5);
      chk(hic, 1);
      @(posedge clk_i);
      uvlo <= 0;
      repeat (394) @(posedge clk_i);
      chk(hic, 1);
      wait_hic(0, 200);
   endtask
   task automatic t_recover();
      state_is(ST_RUN);
      cs_max <= 1;
      max_cl <= 1;
      fb_low <= 1;
      state_is(ST_RECOVER);
      chk(fdis, 1);
      cs_max <= 0;
      max_cl <= 0;
      fb_low <= 0;
      ss_done <= 0;
      ss_eq <= 1;
      state_is(ST_SOFTSTART);
      ss_eq <= 0;
      ss_above <= 1;
      state_is(ST_RECOVER);
      ss_above <= 0;
      max_cl <= 1;
      wait_hic(1, 260);
      chk(hic, 1);
      max_cl <= 0;
      ss_done <= 1;
      wait_hic(0, 400);
   endtask
   task automatic t_stop();
      state_is(ST_RUN);
      for (n = 0; n < 1000 && sr !== 1'b1; n++) @(posedge clk_i);
      chk(sr, 1);
      enable <= 0;
      @(posedge clk_i);
      #1 chk(sr, 0);
      chk(sink, 8'h0F);
      for (n = 0; n < 100 && sink !== 8'h00; n++) begin
         @(posedge clk_i);
         if (sr !== 1'b0) chk(sr, 0);
      end
      state_is(ST_OFF);
   endtask
   task automatic t_light();
      enable <= 1;
      wb(1, `REG_CTRL, 32'h0000_0A00);
      light <= 1;
      min_cl <= 1;
      cnt_gate(60);
      chk(n != 0, 1);
      wb(1, `REG_CTRL, 32'h0000_0A01);
      period();
      cnt_gate(60);
      chk(n, 0);
      @(posedge clk_i);
      min_cl <= 0;
      period();
      period();
      cnt_gate(20);
      chk(n, 10);
      gnd <= 1;
      period();
      cnt_gate(20);
      chk(n, 3);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      t_regs();
      t_start();
      t_ocp(3, 0);
      t_ocp(2, 1);
      t_uvlo();
      t_recover();
      t_stop();
      t_light();
      wrap_up();
   end
endmodule
`default_nettype wire
